// ### verilog/dacc_defs.svh
`ifndef DACC_DEFS_SVH
`define DACC_DEFS_SVH

// Register byte offsets on the bus
`define DACC_OFF_CLK_EN      8'h00
`define DACC_OFF_MODE        8'h04
`define DACC_OFF_CODE        8'h08
`define DACC_OFF_PORT_DIR    8'h0C
`define DACC_OFF_STATUS      8'h10

// Field positions
`define DACC_BIT_CLK_SUPPLY  7
`define DACC_BIT_MODE_SEL    0
`define DACC_BIT_CONV_EN     4
`define DACC_BIT_PIN_DIR     2
`define DACC_BIT_ST_CLK      0
`define DACC_BIT_ST_CONV     1
`define DACC_BIT_ST_RT       2
`define DACC_ST_LEVEL_LSB    8

// Reset values
`define DACC_RST_CLK_EN      8'h00
`define DACC_RST_MODE        8'h00
`define DACC_RST_CODE        8'h00
`define DACC_RST_PORT_DIR    8'hFF
`define DACC_RST_LEVEL       8'h00
`define DACC_RST_RDATA       32'h0000_0000

// Writable bit masks; zero positions are fixed at zero
`define DACC_MASK_CLK_EN     8'hF9
`define DACC_MASK_MODE       8'h33
`define DACC_MASK_CODE       8'hFF
`define DACC_MASK_PORT_DIR   8'hFF

// Bus constants
`define DACC_ADDR_W          8
`define DACC_HTRANS_ACT_BIT  1
`define DACC_HRESP_OKAY      1'b0
`define DACC_ZERO_WORD       32'h0000_0000

`endif

// ### verilog/dacc_pkg.sv
package dacc_pkg;

    // Converter state, one-hot
    typedef enum logic [2:0]
    {
        DACC_ST_OFF  = 3'h1,
        DACC_ST_IDLE = 3'h2,
        DACC_ST_CONV = 3'h4
    } dacc_state_t;

    // Bundle that drives the analog converter
    typedef struct packed
    {
        logic       clk_supply;
        logic       active;
        logic       rt_mode;
        logic [7:0] level;
    } dacc_conv_t;

    // Captured address phase, used during the data phase
    typedef struct packed
    {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } dacc_dphase_t;

endpackage

// ### verilog/dacc_reg8.sv
`timescale 1ns/1ps
`include "dacc_defs.svh"

module dacc_reg8
#(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF
)
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // Write port
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    // Stored value
    output logic      [7:0] o_q
);

    logic [7:0] q;
    logic [7:0] next_q;

    // Whole-register write; fixed-zero positions never take a one
    always_comb
    begin
        next_q = q;
        if (i_wr)
        begin
            next_q = i_wdata & WR_MASK;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            q <= RST_VAL & WR_MASK;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign o_q = q;

endmodule

// ### verilog/dacc_channel_ctrl.sv
`timescale 1ns/1ps
`include "dacc_defs.svh"

module dacc_channel_ctrl
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    // AHB-Lite slave
    input  wire logic              i_hsel,
    input  wire logic [31:0]       i_haddr,
    input  wire logic [1:0]        i_htrans,
    input  wire logic              i_hwrite,
    input  wire logic [2:0]        i_hsize,
    input  wire logic [31:0]       i_hwdata,
    input  wire logic              i_hready,
    output logic                   o_hreadyout,
    output logic                   o_hresp,
    output logic [31:0]            o_hrdata,
    // Real-time output update strobe from the timer logic
    input  wire logic              i_rt_trigger,
    // Converter and shared pin
    output dacc_pkg::dacc_conv_t   o_conv,
    output logic                   o_pin_buffer_oe
);

    // Register values
    logic [7:0]             clk_en_q;
    logic [7:0]             mode_q;
    logic [7:0]             code_q;
    logic [7:0]             port_dir_q;

    // Bus data phase state
    dacc_pkg::dacc_dphase_t dphase;
    dacc_pkg::dacc_dphase_t next_dphase;
    logic [31:0]            next_hrdata;
    logic [31:0]            hrdata;

    // Write strobes for the data phase
    logic                   wr_commit;
    logic                   wr_clk_en;
    logic                   wr_mode;
    logic                   wr_code;
    logic                   wr_port_dir;

    // Converter state
    dacc_pkg::dacc_state_t  state;
    dacc_pkg::dacc_state_t  next_state;
    logic [7:0]             level;
    logic [7:0]             next_level;

    // Decoded control bits
    logic                   clk_supply;
    logic                   conv_en;
    logic                   rt_mode;
    logic [31:0]            status_word;

    // Address phase is taken only when the bus is ready and a real transfer is signalled
    logic                   addr_take;
    assign addr_take = i_hsel && i_hready && i_htrans[`DACC_HTRANS_ACT_BIT];

    // Data phase capture; hsize is not checked, and writes use only the low byte of hwdata
    always_comb
    begin
        next_dphase       = '0;
        next_dphase.valid = addr_take;
        next_dphase.write = addr_take && i_hwrite;
        next_dphase.addr  = i_haddr[`DACC_ADDR_W-1:0];
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            dphase <= '0;
        end
        else
        begin
            dphase <= next_dphase;
        end
    end

    // Write strobes, one register at a time so neighbours are never touched
    assign wr_commit   = dphase.valid && dphase.write;
    assign wr_clk_en   = wr_commit && (dphase.addr == `DACC_OFF_CLK_EN);
    assign wr_mode     = wr_commit && (dphase.addr == `DACC_OFF_MODE);
    assign wr_code     = wr_commit && (dphase.addr == `DACC_OFF_CODE);
    assign wr_port_dir = wr_commit && (dphase.addr == `DACC_OFF_PORT_DIR);

    // Register storage; masks keep the fixed-zero positions at zero
    dacc_reg8
    #(
        .RST_VAL (`DACC_RST_CLK_EN),
        .WR_MASK (`DACC_MASK_CLK_EN)
    )
    u_clk_en
    (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_wr    (wr_clk_en),
        .i_wdata (i_hwdata[7:0]),
        .o_q     (clk_en_q)
    );

    dacc_reg8
    #(
        .RST_VAL (`DACC_RST_MODE),
        .WR_MASK (`DACC_MASK_MODE)
    )
    u_mode
    (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_wr    (wr_mode),
        .i_wdata (i_hwdata[7:0]),
        .o_q     (mode_q)
    );

    dacc_reg8
    #(
        .RST_VAL (`DACC_RST_CODE),
        .WR_MASK (`DACC_MASK_CODE)
    )
    u_code
    (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_wr    (wr_code),
        .i_wdata (i_hwdata[7:0]),
        .o_q     (code_q)
    );

    dacc_reg8
    #(
        .RST_VAL (`DACC_RST_PORT_DIR),
        .WR_MASK (`DACC_MASK_PORT_DIR)
    )
    u_port_dir
    (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_wr    (wr_port_dir),
        .i_wdata (i_hwdata[7:0]),
        .o_q     (port_dir_q)
    );

    // Control bits taken from the registers
    assign clk_supply = clk_en_q[`DACC_BIT_CLK_SUPPLY];
    assign conv_en    = mode_q[`DACC_BIT_CONV_EN];
    assign rt_mode    = mode_q[`DACC_BIT_MODE_SEL];

    // Converter state; without its clock the converter cannot convert
    always_comb
    begin
        next_state = state;
        case (state)
            dacc_pkg::DACC_ST_OFF,
            dacc_pkg::DACC_ST_IDLE,
            dacc_pkg::DACC_ST_CONV:
            begin
                if (!clk_supply)
                begin
                    next_state = dacc_pkg::DACC_ST_OFF;
                end
                else if (conv_en)
                begin
                    next_state = dacc_pkg::DACC_ST_CONV;
                end
                else
                begin
                    next_state = dacc_pkg::DACC_ST_IDLE;
                end
            end
            default:
            begin
                next_state = dacc_pkg::DACC_ST_OFF;
            end
        endcase
    end

    // Applied code: normal mode follows the register, real-time waits for the strobe
    always_comb
    begin
        next_level = `DACC_RST_LEVEL;
        if (state == dacc_pkg::DACC_ST_CONV)
        begin
            if (!rt_mode)
            begin
                next_level = code_q;
            end
            else
            begin
                next_level = i_rt_trigger ? code_q : level;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            state <= dacc_pkg::DACC_ST_OFF;
            level <= `DACC_RST_LEVEL;
        end
        else
        begin
            state <= next_state;
            level <= next_level;
        end
    end

    // Status word shows the converter's own state and applied code
    always_comb
    begin
        status_word                                        = `DACC_ZERO_WORD;
        status_word[`DACC_BIT_ST_CLK]                      = state != dacc_pkg::DACC_ST_OFF;
        status_word[`DACC_BIT_ST_CONV]                     = state == dacc_pkg::DACC_ST_CONV;
        status_word[`DACC_BIT_ST_RT]                       = rt_mode;
        status_word[`DACC_ST_LEVEL_LSB+7:`DACC_ST_LEVEL_LSB] = level;
    end

    // Read data registered at the address phase; unmapped reads return zero
    always_comb
    begin
        next_hrdata = `DACC_ZERO_WORD;
        if (addr_take && !i_hwrite)
        begin
            case (i_haddr[`DACC_ADDR_W-1:0])
                `DACC_OFF_CLK_EN:   next_hrdata = {24'h00_0000, clk_en_q};
                `DACC_OFF_MODE:     next_hrdata = {24'h00_0000, mode_q};
                `DACC_OFF_CODE:     next_hrdata = {24'h00_0000, code_q};
                `DACC_OFF_PORT_DIR: next_hrdata = {24'h00_0000, port_dir_q};
                `DACC_OFF_STATUS:   next_hrdata = status_word;
                default:            next_hrdata = `DACC_ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            hrdata <= `DACC_RST_RDATA;
        end
        else
        begin
            hrdata <= next_hrdata;
        end
    end

    // Zero wait states, so the slave never stretches a transfer
    assign o_hreadyout = 1'b1;
    assign o_hresp     = `DACC_HRESP_OKAY;
    assign o_hrdata    = hrdata;

    // Converter outputs; level is the code, analog value is reference * level / 256
    assign o_conv.clk_supply = clk_supply;
    assign o_conv.active     = state == dacc_pkg::DACC_ST_CONV;
    assign o_conv.rt_mode    = rt_mode;
    assign o_conv.level      = level;

    // Digital buffer drives the pin only in output mode
    assign o_pin_buffer_oe = !port_dir_q[`DACC_BIT_PIN_DIR];

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_wr_dir_out;
        wr_port_dir && !i_hwdata[`DACC_BIT_PIN_DIR];
    endsequence

    sequence s_wr_dir_in;
        wr_port_dir && i_hwdata[`DACC_BIT_PIN_DIR];
    endsequence

    sequence s_read_mode;
        addr_take && !i_hwrite && (i_haddr[`DACC_ADDR_W-1:0] == `DACC_OFF_MODE);
    endsequence

    property p_clk_gate;
        !clk_supply |=> (state == dacc_pkg::DACC_ST_OFF) ##1 (level == `DACC_RST_LEVEL);
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("converter ran without clock");

    property p_normal_follow;
        (state == dacc_pkg::DACC_ST_CONV) && !rt_mode |=> level == $past(code_q);
    endproperty
    a_normal_follow: assert property (p_normal_follow) else $error("normal mode level wrong");

    property p_rt_hold;
        (state == dacc_pkg::DACC_ST_CONV) && rt_mode && !i_rt_trigger |=> $stable(level);
    endproperty
    a_rt_hold: assert property (p_rt_hold) else $error("real-time level moved without strobe");

    property p_rt_load;
        (state == dacc_pkg::DACC_ST_CONV) && rt_mode && i_rt_trigger |=> level == $past(code_q);
    endproperty
    a_rt_load: assert property (p_rt_load) else $error("real-time strobe not applied");

    property p_start;
        clk_supply && conv_en |=> o_conv.active;
    endproperty
    a_start: assert property (p_start) else $error("conversion did not start");

    property p_stop;
        !conv_en |=> !o_conv.active ##1 (level == `DACC_RST_LEVEL);
    endproperty
    a_stop: assert property (p_stop) else $error("conversion did not stop");

    property p_pin_out;
        s_wr_dir_out |=> o_pin_buffer_oe;
    endproperty
    a_pin_out: assert property (p_pin_out) else $error("pin buffer not on");

    property p_pin_in;
        s_wr_dir_in |=> !o_pin_buffer_oe;
    endproperty
    a_pin_in: assert property (p_pin_in) else $error("pin buffer not off");

    property p_fixed_zero;
        ((mode_q & ~`DACC_MASK_MODE) == 8'h00) && ((clk_en_q & ~`DACC_MASK_CLK_EN) == 8'h00);
    endproperty
    a_fixed_zero: assert property (p_fixed_zero) else $error("fixed-zero bit set");

    property p_neighbour_keep;
        wr_code |=> $stable(mode_q) && $stable(clk_en_q);
    endproperty
    a_neighbour_keep: assert property (p_neighbour_keep) else $error("other register changed");

    property p_read_mode;
        s_read_mode |=> o_hrdata == {24'h00_0000, $past(mode_q)};
    endproperty
    a_read_mode: assert property (p_read_mode) else $error("mode readback wrong");

endmodule

// ### testbench/tb_dacc_channel_ctrl.sv
`timescale 1ns/1ps
`include "dacc_defs.svh"

module tb_dacc_channel_ctrl;
    // Clock, reset and bus drive
    logic                 i_clk;
    logic                 i_rst_b;
    logic                 i_hsel;
    logic [31:0]          i_haddr;
    logic [1:0]           i_htrans;
    logic                 i_hwrite;
    logic [2:0]           i_hsize;
    logic [31:0]          i_hwdata;
    logic                 i_hready;
    logic                 i_rt_trigger;
    // Design outputs
    logic                 o_hreadyout;
    logic                 o_hresp;
    logic [31:0]          o_hrdata;
    dacc_pkg::dacc_conv_t o_conv;
    logic                 o_pin_buffer_oe;
    // Bookkeeping
    int                   fails;
    int                   checks;
    int                   cycles;

    dacc_channel_ctrl dut
    (
        .i_clk           (i_clk),
        .i_rst_b         (i_rst_b),
        .i_hsel          (i_hsel),
        .i_haddr         (i_haddr),
        .i_htrans        (i_htrans),
        .i_hwrite        (i_hwrite),
        .i_hsize         (i_hsize),
        .i_hwdata        (i_hwdata),
        .i_hready        (i_hready),
        .o_hreadyout     (o_hreadyout),
        .o_hresp         (o_hresp),
        .o_hrdata        (o_hrdata),
        .i_rt_trigger    (i_rt_trigger),
        .o_conv          (o_conv),
        .o_pin_buffer_oe (o_pin_buffer_oe)
    );

    // Single slave, so its ready is the bus ready
    assign i_hready = o_hreadyout;

    // 100 MHz clock
    always #5 i_clk = ~i_clk;

    // Hang guard, far above the two hundred or so cycles the run needs
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            results();
        end
    end

    task automatic results();
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // One single transfer; waits on ready in both phases
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        @(posedge i_clk);
        i_hsel   <= 1'b1;
        i_haddr  <= {24'h000000, addr};
        i_htrans <= 2'h2;
        i_hwrite <= wr;
        @(posedge i_clk);
        while (i_hready !== 1'b1) @(posedge i_clk);
        i_htrans <= 2'h0;
        i_hwdata <= wdata;
        @(posedge i_clk);
        while (i_hready !== 1'b1) @(posedge i_clk);
        rdata = o_hrdata;
        chk("hresp", 32'h0, {31'h0, o_hresp});
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [31:0] d;
        bus(1'b1, addr, {24'h000000, data}, d);
    endtask

    task automatic rd(input string name, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, addr, 32'h0, d);
        chk(name, exp, d);
    endtask

    // Reset values and an unmapped place
    task automatic t_reset();
        chk("conv after reset", 32'h0, {21'h0, o_conv});
        chk("pin oe after reset", 32'h0, {31'h0, o_pin_buffer_oe});
        rd("clk_en", `DACC_OFF_CLK_EN, 32'h00);
        rd("mode", `DACC_OFF_MODE, 32'h00);
        rd("code", `DACC_OFF_CODE, 32'h00);
        rd("port_dir", `DACC_OFF_PORT_DIR, 32'hFF);
        rd("status", `DACC_OFF_STATUS, 32'h00);
        wr(8'h14, 8'hFF);
        rd("unmapped", 8'h14, 32'h00);
    endtask

    // Fixed-zero positions stay zero; writable bits keep their values
    task automatic t_fixed_bits();
        wr(`DACC_OFF_CLK_EN, 8'hFF);
        rd("clk_en mask", `DACC_OFF_CLK_EN, 32'hF9);
        wr(`DACC_OFF_MODE, 8'hEE);
        rd("mode mask", `DACC_OFF_MODE, 32'h22);
        wr(`DACC_OFF_CLK_EN, 8'h00);
        wr(`DACC_OFF_MODE, 8'h00);
        wr(`DACC_OFF_CODE, 8'h5A);
        rd("code rw", `DACC_OFF_CODE, 32'h5A);
    endtask

    // Top bit of the enable register gates the converter clock
    task automatic t_clock_gate();
        wr(`DACC_OFF_CLK_EN, 8'h80);
        idle(3);
        chk("clk_supply on", 32'h1, {31'h0, o_conv.clk_supply});
        rd("status clk", `DACC_OFF_STATUS, 32'h01);
        wr(`DACC_OFF_CLK_EN, 8'h00);
        idle(3);
        chk("clk_supply off", 32'h0, {31'h0, o_conv.clk_supply});
    endtask

    // Documented start-up order, then codes from 01 up to FF
    task automatic t_convert();
        logic [7:0] codes [4];
        codes = '{8'h01, 8'h80, 8'hA5, 8'hFF};
        wr(`DACC_OFF_CLK_EN, 8'h80);
        wr(`DACC_OFF_MODE, 8'h00);
        wr(`DACC_OFF_CODE, 8'h00);
        wr(`DACC_OFF_MODE, 8'h10);
        idle(3);
        chk("active on", 32'h1, {31'h0, o_conv.active});
        chk("normal mode", 32'h0, {31'h0, o_conv.rt_mode});
        foreach (codes[i])
        begin
            wr(`DACC_OFF_CODE, codes[i]);
            idle(3);
            chk("level", {24'h0, codes[i]}, {24'h0, o_conv.level});
        end
        rd("status conv", `DACC_OFF_STATUS, 32'hFF03);
        wr(`DACC_OFF_MODE, 8'h00);
        idle(3);
        chk("active off", 32'h0, {31'h0, o_conv.active});
        chk("level off", 32'h0, {24'h0, o_conv.level});
    endtask

    // Real-time mode holds the level until the timer strobe
    task automatic t_realtime();
        wr(`DACC_OFF_MODE, 8'h10);
        wr(`DACC_OFF_CODE, 8'h40);
        idle(3);
        chk("level normal", 32'h40, {24'h0, o_conv.level});
        wr(`DACC_OFF_MODE, 8'h11);
        idle(3);
        chk("rt mode", 32'h1, {31'h0, o_conv.rt_mode});
        wr(`DACC_OFF_CODE, 8'h3C);
        idle(3);
        chk("level held", 32'h40, {24'h0, o_conv.level});
        rd("status rt", `DACC_OFF_STATUS, 32'h4007);
        @(posedge i_clk);
        i_rt_trigger <= 1'b1;
        @(posedge i_clk);
        i_rt_trigger <= 1'b0;
        idle(3);
        chk("level strobed", 32'h3C, {24'h0, o_conv.level});
        wr(`DACC_OFF_MODE, 8'h00);
    endtask

    // Shared pin buffer follows its direction bit alone
    task automatic t_pin();
        wr(`DACC_OFF_PORT_DIR, 8'hFB);
        idle(1);
        chk("pin oe out", 32'h1, {31'h0, o_pin_buffer_oe});
        rd("port_dir rw", `DACC_OFF_PORT_DIR, 32'hFB);
        wr(`DACC_OFF_PORT_DIR, 8'h04);
        idle(1);
        chk("pin oe in", 32'h0, {31'h0, o_pin_buffer_oe});
    endtask

    // Reset in mid-run returns registers and outputs to their reset values
    task automatic t_mid_reset();
        wr(`DACC_OFF_CLK_EN, 8'h80);
        wr(`DACC_OFF_MODE, 8'h11);
        wr(`DACC_OFF_PORT_DIR, 8'h00);
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        idle(2);
        i_rst_b <= 1'b1;
        chk("conv after mid reset", 32'h0, {21'h0, o_conv});
        chk("pin oe after mid reset", 32'h0, {31'h0, o_pin_buffer_oe});
        rd("clk_en mid reset", `DACC_OFF_CLK_EN, 32'h00);
        rd("mode mid reset", `DACC_OFF_MODE, 32'h00);
        rd("port_dir mid reset", `DACC_OFF_PORT_DIR, 32'hFF);
    endtask

    initial
    begin
        i_clk        = 1'b0;
        i_rst_b      = 1'b0;
        i_hsel       = 1'b0;
        i_haddr      = 32'h0;
        i_htrans     = 2'h0;
        i_hwrite     = 1'b0;
        i_hsize      = 3'h2;
        i_hwdata     = 32'h0;
        i_rt_trigger = 1'b0;
        fails        = 0;
        checks       = 0;
        cycles       = 0;
        idle(20);
        i_rst_b <= 1'b1;
        t_reset();
        t_fixed_bits();
        t_clock_gate();
        t_convert();
        t_realtime();
        t_pin();
        t_mid_reset();
        results();
    end
endmodule
